// ===== design/csm_top.sv
// Configuration set manager: scratch words, active set, factory profiles and user slots.
// Assumes synchronous access inputs and an acquisition-active level from the camera core.
// Function
// - Five independent signed 32-bit scratch words, writable and readable any time.
// - A scratch selector picks the word that scratch reads and writes reach.
// - Scratch words only store and return values, affecting nothing else.
// - Every parameter write lands in the active set.
// - Active set is volatile and cleared by any reset.
// - Four factory profiles are fixed and never writable.
// - High-gain profile is standard with gain at plus six decibels.
// - Auto profile is standard with continuous auto gain, auto exposure, minimal gain.
// - Default-profile selector picks a factory profile and survives reset.
// - Delivered default-profile selection is the standard profile.
// - Default-profile selector changes only while acquisition is idle.
// - Three persistent user slots, chosen as slot one, two or three.
// - Save copies the whole active set into the selected slot.
// - Saves exclude the lookup table, which software rewrites after startup.
// - Load overwrites active set from default profile or a user slot.
// - Startup profile is loaded into the active set after every reset.
// - Loads happen only while acquisition is idle.
// - Startup selector has exactly four choices: slots one to three or default.
`default_nettype none
`include "csm_regs.svh"
module csm_top
	import csm_pkg::*;
#(
	parameter int N_WORDS = `CSM_N_WORDS,
	parameter int WORD_W  = `CSM_WORD_W,
	parameter int IDX_W   = $clog2(N_WORDS),
	parameter logic [N_WORDS*WORD_W-1:0] STD_PROFILE   = '0,
	parameter logic [N_WORDS*WORD_W-1:0] COLOR_PROFILE = '0
) (
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	input  wire logic                      acq_active,
	input  wire logic                      acc_valid,
	input  wire logic                      acc_write,
	input  wire csm_acc_e                  acc_kind,
	input  wire logic [IDX_W-1:0]          acc_addr,
	input  wire logic [WORD_W-1:0]         acc_wdata,
	output logic                           acc_ready,
	output logic                           acc_done,
	output logic                           acc_err,
	output logic [WORD_W-1:0]              acc_rdata,
	output logic [N_WORDS*WORD_W-1:0]      active_set,
	output csm_prof_e                      dflt_sel,
	output csm_set_e                       start_sel
);
	localparam int NS      = `CSM_N_SCRATCH;
	localparam int CMD_LAT = N_WORDS + 1;
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_WORDS - 1);

	typedef struct packed {
		csm_state_e                  st;
		logic                        boot;
		logic [IDX_W-1:0]            idx;
		csm_set_e                    src;
		csm_set_e                    slot;
		logic [`CSM_SCR_SEL_W-1:0]   scr_sel;
		logic [NS-1:0][WORD_W-1:0]   scr;
		logic [N_WORDS-1:0][WORD_W-1:0] act;
		logic                        rdy;
		logic                        done;
		logic                        err;
		logic [WORD_W-1:0]           rdata;
		csm_prof_e                   dflt_o;
		csm_set_e                    start_o;
	} csm_top_s;

	csm_top_s q;
	csm_top_s next_q;
	logic     acc_take;
	logic     sel_ok;

	csm_nv_if #(.IDX_W(IDX_W), .WORD_W(WORD_W)) nv ();

	csm_nvstore #(
		.N_WORDS (N_WORDS),
		.WORD_W  (WORD_W),
		.N_SLOTS (`CSM_N_SLOTS)
	) u_store (
		.core_clk (core_clk),
		.nv       (nv)
	);

	// Factory profiles are constants derived from the standard one, color from its own parameter, so nothing can write them
	function automatic logic [WORD_W-1:0] fac_word(csm_prof_e p, logic [IDX_W-1:0] i);
		logic [WORD_W-1:0] w;
		w = STD_PROFILE[i*WORD_W +: WORD_W];
		case (p)
			CSM_PROF_HIGAIN: begin
				if (i == IDX_W'(`CSM_GAIN_IDX)) begin
					w = `CSM_GAIN_6DB;
				end
			end
			CSM_PROF_AUTO: begin
				if (i == IDX_W'(`CSM_AUTO_IDX)) begin
					w = `CSM_AUTO_CONT;
				end else if (i == IDX_W'(`CSM_GAIN_IDX)) begin
					w = `CSM_GAIN_MIN;
				end
			end
			CSM_PROF_COLOR: begin
				w = COLOR_PROFILE[i*WORD_W +: WORD_W];
			end
			default: begin
				w = STD_PROFILE[i*WORD_W +: WORD_W];
			end
		endcase
		return w;
	endfunction

	// Access is only taken while idle, so commands never interleave with accesses
	assign acc_take = acc_valid && q.rdy;
	// Four-way selectors: anything above the last code is refused
	assign sel_ok   = acc_wdata < WORD_W'(`CSM_SEL_N);

	// Store port: slot walk uses the same word index as the active set
	assign nv.idx      = q.idx;
	assign nv.wr_slot  = q.slot;
	assign nv.rd_slot  = q.src;
	assign nv.wdata    = q.act[q.idx];
	assign nv.dflt_in  = csm_prof_e'(acc_wdata[`CSM_SEL_W-1:0]);
	assign nv.start_in = csm_set_e'(acc_wdata[`CSM_SEL_W-1:0]);

	// Next-state logic of the whole controller
	always_comb begin
		next_q         = q;
		next_q.done    = 1'b0;
		next_q.err     = 1'b0;
		next_q.dflt_o  = nv.dflt_q;
		next_q.start_o = nv.start_q;
		nv.wr_en       = 1'b0;
		nv.dflt_wr     = 1'b0;
		nv.start_wr    = 1'b0;
		case (q.st)
			CSM_ST_BOOT: begin
				// Startup set taken from the persistent selector
				next_q.src  = nv.start_q;
				next_q.idx  = '0;
				next_q.boot = 1'b1;
				next_q.st   = CSM_ST_LOAD;
			end
			CSM_ST_IDLE: begin
				if (acc_take) begin
					next_q.done  = 1'b1;
					next_q.rdata = `CSM_RDATA_RST;
					case (acc_kind)
						CSM_ACC_ACTIVE: begin
							if (acc_write) begin
								next_q.act[acc_addr] = acc_wdata;
							end else begin
								next_q.rdata = q.act[acc_addr];
							end
						end
						CSM_ACC_SCR_SEL: begin
							if (!acc_write) begin
								next_q.rdata = WORD_W'(q.scr_sel);
							end else if (acc_wdata < WORD_W'(NS)) begin
								next_q.scr_sel = acc_wdata[`CSM_SCR_SEL_W-1:0];
							end else begin
								next_q.err = 1'b1;
							end
						end
						CSM_ACC_SCR_VAL: begin
							// Scratch words drive nothing outside this register
							if (acc_write) begin
								next_q.scr[q.scr_sel] = acc_wdata;
							end else begin
								next_q.rdata = q.scr[q.scr_sel];
							end
						end
						CSM_ACC_DFLT: begin
							if (!acc_write) begin
								next_q.rdata = WORD_W'(nv.dflt_q);
							end else if (acq_active || !sel_ok) begin
								next_q.err = 1'b1;
							end else begin
								nv.dflt_wr = 1'b1;
							end
						end
						CSM_ACC_SLOT: begin
							if (!acc_write) begin
								next_q.rdata = WORD_W'(q.slot);
							end else if (sel_ok) begin
								next_q.slot = csm_set_e'(acc_wdata[`CSM_SEL_W-1:0]);
							end else begin
								next_q.err = 1'b1;
							end
						end
						CSM_ACC_START: begin
							if (!acc_write) begin
								next_q.rdata = WORD_W'(nv.start_q);
							end else if (sel_ok) begin
								nv.start_wr = 1'b1;
							end else begin
								next_q.err = 1'b1;
							end
						end
						CSM_ACC_SAVE: begin
							// The default profile is not a save target
							if (q.slot == CSM_SET_DEFAULT) begin
								next_q.err = 1'b1;
							end else begin
								next_q.done = 1'b0;
								next_q.rdy  = 1'b0;
								next_q.idx  = '0;
								next_q.st   = CSM_ST_SAVE;
							end
						end
						CSM_ACC_LOAD: begin
							if (acq_active) begin
								next_q.err = 1'b1;
							end else begin
								next_q.done = 1'b0;
								next_q.rdy  = 1'b0;
								next_q.src  = q.slot;
								next_q.idx  = '0;
								next_q.boot = 1'b0;
								next_q.st   = CSM_ST_LOAD;
							end
						end
						default: begin
							next_q.err = 1'b1;
						end
					endcase
				end
			end
			CSM_ST_SAVE: begin
				// One word per cycle; the lookup table is not part of the set at all
				nv.wr_en = 1'b1;
				if (q.idx == LAST_IDX) begin
					next_q.st   = CSM_ST_IDLE;
					next_q.rdy  = 1'b1;
					next_q.done = 1'b1;
				end else begin
					next_q.idx = q.idx + IDX_W'(1);
				end
			end
			CSM_ST_LOAD: begin
				// Whole set replaced before any access is taken again
				if (q.src == CSM_SET_DEFAULT) begin
					next_q.act[q.idx] = fac_word(nv.dflt_q, q.idx);
				end else begin
					next_q.act[q.idx] = nv.rdata;
				end
				if (q.idx == LAST_IDX) begin
					next_q.st   = CSM_ST_IDLE;
					next_q.rdy  = 1'b1;
					next_q.done = !q.boot;
					next_q.boot = 1'b0;
				end else begin
					next_q.idx = q.idx + IDX_W'(1);
				end
			end
			default: begin
				next_q.st = CSM_ST_BOOT;
			end
		endcase
	end

	// Volatile state clears on reset, the user set selector to slot one, then the startup set is loaded
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q         <= '0;
			q.st      <= CSM_ST_BOOT;
			q.slot    <= CSM_SET_SLOT1;
			q.src     <= CSM_SET_DEFAULT;
			q.dflt_o  <= CSM_PROF_STD;
			q.start_o <= CSM_SET_DEFAULT;
		end else begin
			q <= next_q;
		end
	end

	// All outputs straight from the state register
	assign acc_ready  = q.rdy;
	assign acc_done   = q.done;
	assign acc_err    = q.err;
	assign acc_rdata  = q.rdata;
	assign active_set = q.act;
	assign dflt_sel   = q.dflt_o;
	assign start_sel  = q.start_o;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	// Scratch write reaches the selected word and is answered done
	property p_scr_write;
		acc_take && acc_write && acc_kind == CSM_ACC_SCR_VAL |=>
			q.scr[$past(q.scr_sel)] == $past(acc_wdata) && acc_done;
	endproperty
	a_scr_write: assert property (p_scr_write) else $error("scratch write lost");

	// Scratch selector never leaves the five legal words
	property p_scr_sel_range;
		acc_take && acc_write && acc_kind == CSM_ACC_SCR_SEL && acc_wdata >= WORD_W'(NS) |=>
			acc_err && q.scr_sel == $past(q.scr_sel);
	endproperty
	a_scr_sel_range: assert property (p_scr_sel_range) else $error("bad scratch select taken");

	// Scratch traffic leaves the active set alone
	property p_scr_isolated;
		acc_take && acc_kind == CSM_ACC_SCR_VAL |=> active_set == $past(active_set);
	endproperty
	a_scr_isolated: assert property (p_scr_isolated) else $error("scratch touched active set");

	// Active write lands in the addressed word
	property p_active_write;
		acc_take && acc_write && acc_kind == CSM_ACC_ACTIVE |=>
			active_set[$past(acc_addr)*WORD_W +: WORD_W] == $past(acc_wdata);
	endproperty
	a_active_write: assert property (p_active_write) else $error("active write lost");

	// Default selector held while acquiring
	property p_dflt_reject;
		acc_take && acc_write && acc_kind == CSM_ACC_DFLT && acq_active |=>
			acc_err ##1 dflt_sel == $past(dflt_sel, 2);
	endproperty
	a_dflt_reject: assert property (p_dflt_reject) else $error("default select taken while busy");

	// Load refused while acquiring, set unchanged
	property p_load_reject;
		acc_take && acc_kind == CSM_ACC_LOAD && acq_active |=>
			acc_err && acc_ready && active_set == $past(active_set);
	endproperty
	a_load_reject: assert property (p_load_reject) else $error("load taken while busy");

	// Save runs the whole set and then answers
	property p_save_len;
		acc_take && acc_kind == CSM_ACC_SAVE && q.slot != CSM_SET_DEFAULT |->
			##1 !acc_ready ##(CMD_LAT - 1) (acc_done && acc_ready);
	endproperty
	a_save_len: assert property (p_save_len) else $error("save length wrong");

	// No access taken while a command walks the set
	property p_busy;
		q.st == CSM_ST_SAVE || q.st == CSM_ST_LOAD |-> !acc_ready && !acc_done;
	endproperty
	a_busy: assert property (p_busy) else $error("access open during command");

	// Startup load finishes in a fixed time after reset
	property p_boot;
		q.st == CSM_ST_BOOT |-> !acc_ready ##CMD_LAT (acc_ready && !acc_done);
	endproperty
	a_boot: assert property (p_boot) else $error("startup load timing wrong");

	// Save to the default code is refused
	property p_save_default;
		acc_take && acc_kind == CSM_ACC_SAVE && q.slot == CSM_SET_DEFAULT |=> acc_err && acc_ready;
	endproperty
	a_save_default: assert property (p_save_default) else $error("save to default taken");

	c_save: cover property (acc_take && acc_kind == CSM_ACC_SAVE ##CMD_LAT acc_done);
	c_load: cover property (acc_take && acc_kind == CSM_ACC_LOAD && !acq_active ##CMD_LAT acc_done);
	c_reject: cover property (acc_take && acc_kind == CSM_ACC_DFLT && acc_write && acq_active);
	c_boot_slot: cover property (q.st == CSM_ST_BOOT && nv.start_q != CSM_SET_DEFAULT);
endmodule
`default_nettype wire

// ===== design/csm_regs.svh
// Constants of the configuration set manager: sizes, field positions and reset values.
// Assumes inclusion by csm_pkg.sv and the design modules by bare name.
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

`define CSM_WORD_W      32
`define CSM_N_SCRATCH   5
`define CSM_N_WORDS     8
`define CSM_N_SLOTS     3
`define CSM_SEL_W       2
`define CSM_SEL_N       4
`define CSM_SCR_SEL_W   3
// Word positions inside the active set
`define CSM_GAIN_IDX    0
`define CSM_AUTO_IDX    1
// Gain word in dB, auto word: bit 0 gain auto continuous, bit 1 exposure auto continuous
`define CSM_GAIN_6DB    32'h0000_0006
`define CSM_GAIN_MIN    32'h0000_0000
`define CSM_AUTO_CONT   32'h0000_0003
`define CSM_AUTO_OFF    32'h0000_0000
// Reset values of the volatile state
`define CSM_WORD_RST    32'h0000_0000
`define CSM_RDATA_RST   32'h0000_0000

`endif

// ===== design/csm_pkg.sv
// Types shared by the configuration set manager modules.
// Assumes csm_regs.svh is on the include path.
`default_nettype none
`include "csm_regs.svh"
package csm_pkg;
	// Factory profiles; the delivered default is the standard one
	typedef enum logic [`CSM_SEL_W-1:0] {
		CSM_PROF_STD    = 2'h0,
		CSM_PROF_HIGAIN = 2'h1,
		CSM_PROF_AUTO   = 2'h2,
		CSM_PROF_COLOR  = 2'h3
	} csm_prof_e;
	// Source or target set: default profile or user slot 1..3
	typedef enum logic [`CSM_SEL_W-1:0] {
		CSM_SET_DEFAULT = 2'h0,
		CSM_SET_SLOT1   = 2'h1,
		CSM_SET_SLOT2   = 2'h2,
		CSM_SET_SLOT3   = 2'h3
	} csm_set_e;
	// Parameter access kinds
	typedef enum logic [2:0] {
		CSM_ACC_ACTIVE  = 3'h0,
		CSM_ACC_SCR_SEL = 3'h1,
		CSM_ACC_SCR_VAL = 3'h2,
		CSM_ACC_DFLT    = 3'h3,
		CSM_ACC_SLOT    = 3'h4,
		CSM_ACC_START   = 3'h5,
		CSM_ACC_SAVE    = 3'h6,
		CSM_ACC_LOAD    = 3'h7
	} csm_acc_e;
	// Controller states, Gray along boot, load, idle, save
	typedef enum logic [1:0] {
		CSM_ST_BOOT = 2'h0,
		CSM_ST_LOAD = 2'h1,
		CSM_ST_IDLE = 2'h3,
		CSM_ST_SAVE = 2'h2
	} csm_state_e;
endpackage
`default_nettype wire

// ===== design/csm_nv_if.sv
// Carrier between the controller and the non-volatile store.
// Assumes one clock; the store reads combinationally.
`default_nettype none
`include "csm_regs.svh"
interface csm_nv_if
	import csm_pkg::*;
#(
	parameter int IDX_W  = 3,
	parameter int WORD_W = `CSM_WORD_W
);
	logic              wr_en;
	csm_set_e          wr_slot;
	csm_set_e          rd_slot;
	logic [IDX_W-1:0]  idx;
	logic [WORD_W-1:0] wdata;
	logic [WORD_W-1:0] rdata;
	logic              dflt_wr;
	csm_prof_e         dflt_in;
	csm_prof_e         dflt_q;
	logic              start_wr;
	csm_set_e          start_in;
	csm_set_e          start_q;
	modport ctl (output wr_en, wr_slot, rd_slot, idx, wdata, dflt_wr, dflt_in, start_wr, start_in,
		input rdata, dflt_q, start_q);
	modport mem (input wr_en, wr_slot, rd_slot, idx, wdata, dflt_wr, dflt_in, start_wr, start_in,
		output rdata, dflt_q, start_q);
endinterface
`default_nettype wire

// ===== design/csm_nvstore.sv
// Non-volatile part: three user slots and the two persistent selectors.
// Assumes a storage that keeps its contents over reset; no reset reaches it.
`default_nettype none
`include "csm_regs.svh"
module csm_nvstore
	import csm_pkg::*;
#(
	parameter int N_WORDS = `CSM_N_WORDS,
	parameter int WORD_W  = `CSM_WORD_W,
	parameter int N_SLOTS = `CSM_N_SLOTS
) (
	input wire logic core_clk,
	csm_nv_if.mem    nv
);
	typedef struct packed {
		csm_prof_e dflt;
		csm_set_e  start;
	} csm_nv_s;

	// Delivered state: standard profile as default, default set at startup
	csm_nv_s q = '{dflt: CSM_PROF_STD, start: CSM_SET_DEFAULT};
	csm_nv_s next_q;
	logic [WORD_W-1:0] slot_mem [1:N_SLOTS][N_WORDS];

	// Selector updates; legality is checked by the controller
	always_comb begin
		next_q = q;
		if (nv.dflt_wr) begin
			next_q.dflt = nv.dflt_in;
		end
		if (nv.start_wr) begin
			next_q.start = nv.start_in;
		end
	end

	// No reset on purpose: this state must outlive it
	always_ff @(posedge core_clk) begin
		q <= next_q;
		if (nv.wr_en && nv.wr_slot != CSM_SET_DEFAULT) begin
			slot_mem[nv.wr_slot][nv.idx] <= nv.wdata;
		end
	end

	assign nv.dflt_q  = q.dflt;
	assign nv.start_q = q.start;
	// Default code has no slot behind it
	assign nv.rdata   = (nv.rd_slot == CSM_SET_DEFAULT) ? '0 : slot_mem[nv.rd_slot][nv.idx];
endmodule
`default_nettype wire

// ===== sim/csm_host.sv
// Host-side partner: issues parameter accesses on the access port of the set manager.
// Assumes one caller at a time; it changes its outputs only at falling clock edges.
`default_nettype none
module csm_host
	import csm_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        acc_ready,
	input  wire logic        acc_done,
	input  wire logic        acc_err,
	input  wire logic [31:0] acc_rdata,
	output var  logic        acc_valid,
	output var  logic        acc_write,
	output var  csm_acc_e    acc_kind,
	output var  logic [2:0]  acc_addr,
	output var  logic [31:0] acc_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle request lines from time zero
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_kind  = CSM_ACC_ACTIVE;
		acc_addr  = 3'h0;
		acc_wdata = 32'h0;
	end

	// One access: request held until taken, answer sampled at falling edges so no pulse is missed
	task automatic access(input csm_acc_e k, input logic w, input logic [2:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er, output logic to);
		int n;
		to = 1'b1;
		er = 1'b0;
		rd = 32'h0;
		@(negedge core_clk);
		acc_kind  = k;
		acc_write = w;
		acc_addr  = a;
		acc_wdata = d;
		acc_valid = 1'b1;
		// Ready is a register: a high level seen here still stands at the coming take edge
		for (n = 0; n < 50; n++) begin
			if (acc_ready === 1'b1) break;
			@(negedge core_clk);
		end
		if (n < 50) begin
			@(posedge core_clk);
			@(negedge core_clk);
			// Released address and data lines carry the inverse, never a stale copy
			acc_valid = 1'b0;
			acc_addr  = ~a;
			acc_wdata = ~d;
			for (n = 0; n < 20; n++) begin
				if (acc_done === 1'b1 || acc_err === 1'b1) begin
					rd = acc_rdata;
					er = acc_err;
					to = 1'b0;
					break;
				end
				@(negedge core_clk);
			end
		end
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench: integer model of scratch words, active set, profiles and user slots.
// Assumes csm_pkg, csm_top and csm_host are compiled before it.
`default_nettype none
module tb
	import csm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// Factory contents: word i of standard is 100h+i, of color 200h+i
	function automatic logic [255:0] mk(input int b);
		logic [255:0] v;
		for (int i = 0; i < 8; i++) v[i*32+:32] = 32'(b + i);
		return v;
	endfunction

	logic         core_clk;
	logic         rstn;
	logic         acq_active;
	logic         acc_valid;
	logic         acc_write;
	logic         acc_ready;
	logic         acc_done;
	logic         acc_err;
	csm_acc_e     acc_kind;
	logic [2:0]   acc_addr;
	logic [31:0]  acc_wdata;
	logic [31:0]  acc_rdata;
	logic [31:0]  rd;
	logic [255:0] active_set;
	csm_prof_e    dflt_sel;
	csm_set_e     start_sel;
	int           err_count;
	int           checks;
	int           seed;
	int           dflt;
	int           start;
	int           act[8];
	int           scr[5];
	int           sv[4][8];

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	csm_top #(.STD_PROFILE(mk(32'h100)), .COLOR_PROFILE(mk(32'h200))) DUT (.core_clk, .rstn, .acq_active,
		.acc_valid, .acc_write, .acc_kind, .acc_addr, .acc_wdata, .acc_ready, .acc_done, .acc_err,
		.acc_rdata, .active_set, .dflt_sel, .start_sel);

	csm_host u_host (.core_clk, .acc_ready, .acc_done, .acc_err, .acc_rdata, .acc_valid, .acc_write,
		.acc_kind, .acc_addr, .acc_wdata);

	task automatic chk(input logic c, input string m);
		checks++;
		if (c !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One access; a missing answer ends the run
	task automatic op(input csm_acc_e k, input logic w, input int a, input int d, input logic xe);
		logic er;
		logic to;
		u_host.access(k, w, 3'(a), 32'(d), rd, er, to);
		if (to) begin
			err_count++;
			$display("CHECK FAILED at %0t: no answer", $time);
			wrap_up();
		end
		chk(er === xe, "done or refusal wrong");
	endtask

	// Expected active set after loading factory profile p
	task automatic prof(input int p);
		for (int i = 0; i < 8; i++) act[i] = (p == 3) ? 32'h200 + i : 32'h100 + i;
		if (p == 1) act[0] = 6;
		if (p == 2) begin
			act[0] = 0;
			act[1] = 3;
		end
	endtask

	task automatic cmp_set();
		for (int i = 0; i < 8; i++) chk(active_set[i*32+:32] === 32'(act[i]), "active word");
	endtask

	// Reset for 20 cycles, then the startup set must appear without a request
	task automatic do_reset();
		int n;
		@(negedge core_clk);
		rstn = 1'b0;
		repeat (20) @(negedge core_clk);
		chk(active_set === 256'h0, "active set kept over reset");
		rstn = 1'b1;
		for (n = 0; n < 40 && acc_ready !== 1'b1; n++) @(negedge core_clk);
		if (n == 40) begin
			err_count++;
			$display("CHECK FAILED at %0t: never ready", $time);
			wrap_up();
		end
		if (start == 0) prof(dflt);
		else act = sv[start];
		cmp_set();
		chk(dflt_sel === 2'(dflt), "default selector lost");
		chk(start_sel === 2'(start), "startup selector lost");
		$display("reset test done");
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		acq_active = 1'b0;
		seed = 95651;
		err_count = 0;
		checks = 0;
		dflt = 0;
		start = 0;
		do_reset();
		for (int i = 0; i < 5; i++) begin
			scr[i] = $random(seed);
			op(CSM_ACC_SCR_SEL, 1'b1, 0, i, 1'b0);
			op(CSM_ACC_SCR_VAL, 1'b1, 0, scr[i], 1'b0);
		end
		for (int i = 4; i >= 0; i--) begin
			op(CSM_ACC_SCR_SEL, 1'b1, 0, i, 1'b0);
			op(CSM_ACC_SCR_VAL, 1'b0, 0, 0, 1'b0);
			chk(rd === 32'(scr[i]), "scratch readback");
		end
		op(CSM_ACC_SCR_SEL, 1'b1, 0, 5, 1'b1);
		op(CSM_ACC_SCR_SEL, 1'b0, 0, 0, 1'b0);
		chk(rd === 32'h0, "scratch selector read");
		cmp_set();
		$display("scratch test done");
		for (int i = 0; i < 8; i++) begin
			act[i] = $random(seed);
			op(CSM_ACC_ACTIVE, 1'b1, i, act[i], 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			op(CSM_ACC_ACTIVE, 1'b0, i, 0, 1'b0);
			chk(rd === 32'(act[i]), "active readback");
		end
		cmp_set();
		// Save to slot two, spoil a word, load it back
		op(CSM_ACC_SLOT, 1'b1, 0, 2, 1'b0);
		op(CSM_ACC_SAVE, 1'b1, 0, 0, 1'b0);
		sv[2] = act;
		act[3] = ~act[3];
		op(CSM_ACC_ACTIVE, 1'b1, 3, act[3], 1'b0);
		op(CSM_ACC_LOAD, 1'b1, 0, 0, 1'b0);
		act = sv[2];
		cmp_set();
		op(CSM_ACC_SLOT, 1'b1, 0, 0, 1'b0);
		op(CSM_ACC_SAVE, 1'b1, 0, 0, 1'b1);
		op(CSM_ACC_SLOT, 1'b1, 0, 4, 1'b1);
		op(CSM_ACC_SLOT, 1'b0, 0, 0, 1'b0);
		chk(rd === 32'h0, "user set selector read");
		$display("save and load test done");
		// Every factory profile as default, loaded through selector zero
		for (int p = 0; p < 4; p++) begin
			op(CSM_ACC_DFLT, 1'b1, 0, p, 1'b0);
			op(CSM_ACC_LOAD, 1'b1, 0, 0, 1'b0);
			dflt = p;
			prof(p);
			cmp_set();
			chk(dflt_sel === 2'(p), "default selector");
		end
		op(CSM_ACC_DFLT, 1'b0, 0, 0, 1'b0);
		chk(rd === 32'(dflt), "default selector read");
		op(CSM_ACC_DFLT, 1'b1, 0, 4, 1'b1);
		$display("profile test done");
		// Acquisition running: selector change and load refused
		@(negedge core_clk);
		acq_active = 1'b1;
		op(CSM_ACC_DFLT, 1'b1, 0, 1, 1'b1);
		op(CSM_ACC_LOAD, 1'b1, 0, 0, 1'b1);
		cmp_set();
		chk(dflt_sel === 2'(dflt), "selector changed while busy");
		@(negedge core_clk);
		acq_active = 1'b0;
		$display("busy test done");
		op(CSM_ACC_START, 1'b1, 0, 4, 1'b1);
		op(CSM_ACC_START, 1'b1, 0, 2, 1'b0);
		op(CSM_ACC_START, 1'b0, 0, 0, 1'b0);
		chk(rd === 32'h2, "startup selector read");
		start = 2;
		do_reset();
		op(CSM_ACC_START, 1'b1, 0, 0, 1'b0);
		op(CSM_ACC_DFLT, 1'b1, 0, 1, 1'b0);
		start = 0;
		dflt = 1;
		do_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
